// ===== logic/pces_map.vh
// constants for the credit and completion-error sideband block
`ifndef PCES_MAP_VH
`define PCES_MAP_VH
`define PCES_BIT_PH        5
`define PCES_BIT_PD        4
`define PCES_BIT_NPH       3
`define PCES_BIT_NPD       2
`define PCES_BIT_CPLH      1
`define PCES_BIT_CPLD      0
`define PCES_SEL_POSTED    2'h0
`define PCES_SEL_NONPOSTED 2'h1
`define PCES_SEL_CPL       2'h2
`define PCES_ERR_CTO_COR   0
`define PCES_ERR_CTO_UNC   1
`define PCES_ERR_CA        2
`define PCES_ERR_UC        3
`define PCES_ERR_UR_P      4
`define PCES_ERR_UR_NP     5
`define PCES_ERR_LOGHDR    6
`define PCES_MSG_COR       2'h0
`define PCES_MSG_NONFATAL  2'h1
`define PCES_MSG_FATAL     2'h2
`define PCES_HDR_BYTES     20
`define PCES_DATA_BYTES    16
`define PCES_SEL_LATENCY   2
`endif

// ===== logic/pces_sideband.v
// credit reporting and completion-error sideband logic
`timescale 1ns/1ps
`include "pces_map.vh"
module pces_sideband #(
	parameter PF_W        = 2,
	parameter HDR_W       = 8,
	parameter DATA_W      = 12,
	parameter CONS_SEL_EN = 1
) (
	// clock and reset
	input  wire               core_clk,
	input  wire               rstn,
	// link state and limits from the far end
	input  wire               link_up,
	input  wire [5:0]         infinite_advertised,
	input  wire               limit_load,
	input  wire [HDR_W-1:0]   limit_ph,
	input  wire [DATA_W-1:0]  limit_pd,
	input  wire [HDR_W-1:0]   limit_nph,
	input  wire [DATA_W-1:0]  limit_npd,
	input  wire [HDR_W-1:0]   limit_cplh,
	input  wire [DATA_W-1:0]  limit_cpld,
	// credit use: core-generated and application packets
	input  wire               core_tlp_use,
	input  wire [1:0]         core_tlp_class,
	input  wire               core_tlp_has_data,
	input  wire               app_tlp_use,
	input  wire [1:0]         app_tlp_class,
	input  wire               app_tlp_has_data,
	// credit reporting
	input  wire [1:0]         credit_class_select,
	input  wire               consumed_select,
	output reg  [5:0]         core_consumed_credit_pulse,
	output reg  [5:0]         infinite_credit_flags,
	output reg  [HDR_W-1:0]   header_credit_value,
	output reg  [DATA_W-1:0]  data_credit_value,
	output reg                transmit_ready_out,
	// completion error reporting
	input  wire [6:0]         cpl_err,
	input  wire [PF_W-1:0]    error_phys_function_number,
	input  wire               error_from_virtual_function,
	input  wire [10:0]        error_virt_function_offset,
	input  wire [127:0]       log_hdr,
	input  wire [5:0]         uncor_severity_fatal,
	// error log and message outputs
	output reg  [5:0]         error_status,
	output reg  [127:0]       logged_header,
	output reg                header_logged,
	output reg  [PF_W-1:0]    logged_pf,
	output reg                logged_vf_active,
	output reg  [10:0]        logged_vf_offset,
	output reg                msg_valid,
	output reg  [1:0]         msg_type,
	output reg  [5:0]         msg_source
);
	// decoded credit use per type, same bit order as the pulse vector
	reg  [5:0]              use_vec;
	reg  [5:0]              core_vec;

	// per-class counters and limits, flattened so one slice feeds the select mux
	wire [3*HDR_W-1:0]      hcons_flat;
	wire [3*DATA_W-1:0]     dcons_flat;
	wire [3*HDR_W-1:0]      hlim_flat;
	wire [3*DATA_W-1:0]     dlim_flat;
	wire [3*HDR_W-1:0]      hlim_in;
	wire [3*DATA_W-1:0]     dlim_in;
	wire [5:0]              exhaust;

	// select pipeline and the value it picks
	reg  [1:0]              sel_reg;
	wire                    show_cons;
	reg  [HDR_W-1:0]        hdr_pick;
	reg  [DATA_W-1:0]       data_pick;

	// error queue: one pending flag per error bit
	localparam [2:0]        PICK_NONE = 3'h7;
	wire [5:0]              pend_vec;
	reg  [2:0]              pick;
	reg  [1:0]              mtype;
	integer                 i;
	genvar                  c;
	genvar                  b;

	assign show_cons = (CONS_SEL_EN != 0) && consumed_select;
	assign hlim_in   = {limit_cplh, limit_nph, limit_ph};
	assign dlim_in   = {limit_cpld, limit_npd, limit_pd};

	// application packets only feed the counters, never the pulse vector
	always @* begin
		use_vec = 6'h00;
		if (app_tlp_use) begin
			case (app_tlp_class)
				`PCES_SEL_POSTED: begin
					use_vec[`PCES_BIT_PH] = 1'b1;
					use_vec[`PCES_BIT_PD] = app_tlp_has_data;
				end
				`PCES_SEL_NONPOSTED: begin
					use_vec[`PCES_BIT_NPH] = 1'b1;
					use_vec[`PCES_BIT_NPD] = app_tlp_has_data;
				end
				`PCES_SEL_CPL: begin
					use_vec[`PCES_BIT_CPLH] = 1'b1;
					use_vec[`PCES_BIT_CPLD] = app_tlp_has_data;
				end
				default: begin
					use_vec = 6'h00;
				end
			endcase
		end
	end

	// core packets: one header, and one data credit only if it carries data
	always @* begin
		core_vec = 6'h00;
		if (core_tlp_use) begin
			case (core_tlp_class)
				`PCES_SEL_POSTED: begin
					core_vec[`PCES_BIT_PH] = 1'b1;
					core_vec[`PCES_BIT_PD] = core_tlp_has_data;
				end
				`PCES_SEL_NONPOSTED: begin
					core_vec[`PCES_BIT_NPH] = 1'b1;
					core_vec[`PCES_BIT_NPD] = core_tlp_has_data;
				end
				`PCES_SEL_CPL: begin
					core_vec[`PCES_BIT_CPLH] = 1'b1;
					core_vec[`PCES_BIT_CPLD] = core_tlp_has_data;
				end
				default: begin
					core_vec = 6'h00;
				end
			endcase
		end
	end

	// one counter pair and one limit pair per credit class
	generate
		for (c = 0; c < 3; c = c + 1) begin : g_class
			reg  [HDR_W-1:0]  hcons_reg;
			reg  [DATA_W-1:0] dcons_reg;
			reg  [HDR_W-1:0]  hlim_reg;
			reg  [DATA_W-1:0] dlim_reg;
			wire              hdr_take;
			wire              data_take;

			// app and core packets share the counter; only core ones pulse
			assign hdr_take  = use_vec[5-2*c] | core_vec[5-2*c];
			assign data_take = use_vec[4-2*c] | core_vec[4-2*c];

			// counters restart with the link so a retrain starts from zero
			always @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					hcons_reg <= {HDR_W{1'b0}};
					dcons_reg <= {DATA_W{1'b0}};
				end else if (!link_up) begin
					hcons_reg <= {HDR_W{1'b0}};
					dcons_reg <= {DATA_W{1'b0}};
				end else begin
					hcons_reg <= hcons_reg + {{(HDR_W-1){1'b0}}, hdr_take};
					dcons_reg <= dcons_reg + {{(DATA_W-1){1'b0}}, data_take};
				end
			end

			// limits are absolute cumulative values, held while load is low
			always @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					hlim_reg <= {HDR_W{1'b0}};
					dlim_reg <= {DATA_W{1'b0}};
				end else if (limit_load) begin
					hlim_reg <= hlim_in[c*HDR_W +: HDR_W];
					dlim_reg <= dlim_in[c*DATA_W +: DATA_W];
				end
			end

			// a finite type whose counter meets its limit blocks sending
			assign exhaust[5-2*c] = !infinite_advertised[5-2*c] && (hcons_reg == hlim_reg);
			assign exhaust[4-2*c] = !infinite_advertised[4-2*c] && (dcons_reg == dlim_reg);
			assign hcons_flat[c*HDR_W +: HDR_W]   = hcons_reg;
			assign dcons_flat[c*DATA_W +: DATA_W] = dcons_reg;
			assign hlim_flat[c*HDR_W +: HDR_W]    = hlim_reg;
			assign dlim_flat[c*DATA_W +: DATA_W]  = dlim_reg;
		end
	endgenerate

	// pulses held low until link up so nothing leaks early
	// ready trails the counters by one clock; a sender must allow for that
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			core_consumed_credit_pulse <= 6'h00;
			infinite_credit_flags      <= 6'h00;
			transmit_ready_out         <= 1'b0;
			sel_reg                    <= 2'h0;
		end else begin
			core_consumed_credit_pulse <= link_up ? core_vec : 6'h00;
			infinite_credit_flags      <= link_up ? infinite_advertised : 6'h00;
			transmit_ready_out         <= link_up && (exhaust == 6'h00);
			sel_reg                    <= credit_class_select;
		end
	end

	// select registered once above, output registered once below: two clocks
	always @* begin
		hdr_pick  = {HDR_W{1'b0}};
		data_pick = {DATA_W{1'b0}};
		case (sel_reg)
			`PCES_SEL_POSTED: begin
				hdr_pick  = show_cons ? hcons_flat[0 +: HDR_W] : hlim_flat[0 +: HDR_W];
				data_pick = show_cons ? dcons_flat[0 +: DATA_W] : dlim_flat[0 +: DATA_W];
			end
			`PCES_SEL_NONPOSTED: begin
				hdr_pick  = show_cons ? hcons_flat[HDR_W +: HDR_W] : hlim_flat[HDR_W +: HDR_W];
				data_pick = show_cons ? dcons_flat[DATA_W +: DATA_W] : dlim_flat[DATA_W +: DATA_W];
			end
			`PCES_SEL_CPL: begin
				hdr_pick  = show_cons ? hcons_flat[2*HDR_W +: HDR_W] : hlim_flat[2*HDR_W +: HDR_W];
				data_pick = show_cons ? dcons_flat[2*DATA_W +: DATA_W] : dlim_flat[2*DATA_W +: DATA_W];
			end
			default: begin
				// code 11 is undefined; zero keeps the outputs quiet
				hdr_pick  = {HDR_W{1'b0}};
				data_pick = {DATA_W{1'b0}};
			end
		endcase
	end

	// second stage of the select latency
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			header_credit_value <= {HDR_W{1'b0}};
			data_credit_value   <= {DATA_W{1'b0}};
		end else begin
			header_credit_value <= hdr_pick;
			data_credit_value   <= data_pick;
		end
	end

	// a report arriving as its older twin is sent stays pending: set wins
	generate
		for (b = 0; b < 6; b = b + 1) begin : g_err
			reg  pend_reg;
			reg  pend_next;
			wire sent;

			assign sent = (pick == b);
			always @* begin
				pend_next = pend_reg;
				if (sent)
					pend_next = 1'b0;
				if (cpl_err[b])
					pend_next = 1'b1;
			end
			always @(posedge core_clk or negedge rstn) begin
				if (!rstn)
					pend_reg <= 1'b0;
				else
					pend_reg <= pend_next;
			end
			assign pend_vec[b] = pend_reg;
		end
	endgenerate

	// lowest pending bit goes first; one message per clock
	always @* begin
		pick = PICK_NONE;
		for (i = 5; i >= 0; i = i - 1) begin
			if (pend_vec[i])
				pick = i[2:0];
		end
	end

	// bit 0 is always correctable; the rest are fatal when programmed so, else non-fatal for bits 1 and 4 and correctable for bits 2, 3 and 5
	always @* begin
		case (pick)
			3'h0:    mtype = `PCES_MSG_COR;
			3'h1:    mtype = uncor_severity_fatal[1] ? `PCES_MSG_FATAL : `PCES_MSG_NONFATAL;
			3'h2:    mtype = uncor_severity_fatal[2] ? `PCES_MSG_FATAL : `PCES_MSG_COR;
			3'h3:    mtype = uncor_severity_fatal[3] ? `PCES_MSG_FATAL : `PCES_MSG_COR;
			3'h4:    mtype = uncor_severity_fatal[4] ? `PCES_MSG_FATAL : `PCES_MSG_NONFATAL;
			3'h5:    mtype = uncor_severity_fatal[5] ? `PCES_MSG_FATAL : `PCES_MSG_COR;
			default: mtype = `PCES_MSG_COR;
		endcase
	end

	// status is sticky until reset; the log keeps the latest reporter
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			error_status     <= 6'h00;
			logged_header    <= 128'h0;
			header_logged    <= 1'b0;
			logged_pf        <= {PF_W{1'b0}};
			logged_vf_active <= 1'b0;
			logged_vf_offset <= 11'h000;
		end else begin
			error_status <= error_status | cpl_err[5:0];
			if (cpl_err[5:0] != 6'h00) begin
				logged_pf        <= error_phys_function_number;
				logged_vf_active <= error_from_virtual_function;
				logged_vf_offset <= error_from_virtual_function ? error_virt_function_offset : 11'h000;
			end
			// header captured only alongside bits 2..5
			if (cpl_err[`PCES_ERR_LOGHDR] && (cpl_err[5:2] != 4'h0)) begin
				logged_header <= log_hdr;
				header_logged <= 1'b1;
			end
		end
	end

	// message outputs come straight from flops; type is frozen with the source
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			msg_valid  <= 1'b0;
			msg_type   <= 2'h0;
			msg_source <= 6'h00;
		end else begin
			msg_valid  <= (pick != PICK_NONE);
			msg_type   <= mtype;
			msg_source <= (pick != PICK_NONE) ? (6'h01 << pick) : 6'h00;
		end
	end
endmodule // pces_sideband

// ===== verification/pces_chk.sv
// bound checker for the credit and error sideband ports
`timescale 1ns/1ps
module pces_chk (
	// clock and reset
	input wire       core_clk,
	input wire       rstn,
	// credit side
	input wire       link_up,
	input wire       core_tlp_use,
	input wire [1:0] core_tlp_class,
	input wire       core_tlp_has_data,
	input wire [5:0] core_consumed_credit_pulse,
	input wire       transmit_ready_out,
	// error side
	input wire [6:0] cpl_err,
	input wire [5:0] uncor_severity_fatal,
	input wire [5:0] error_status,
	input wire       msg_valid,
	input wire [1:0] msg_type,
	input wire [5:0] msg_source
);
	wire [5:0] p = core_consumed_credit_pulse;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	core_pulse_a: assert property (core_tlp_use && link_up && core_tlp_class != 2'h3 |=>
		p == ((6'h02 | $past(core_tlp_has_data)) << (4 - 2 * $past(core_tlp_class)))) else $error("bad pulse");
	no_app_pulse_a: assert property (!core_tlp_use |=> p == 6'h00) else $error("stray pulse");
	one_header_a: assert property ($onehot0({p[5], p[3], p[1]}) && (p & 6'h15 & ~(p >> 1)) == 6'h00)
		else $error("pulse pairing");
	link_down_a: assert property (!link_up |=> p == 6'h00 && !transmit_ready_out) else $error("link down");
	status_set_a: assert property (|cpl_err[5:0] |=> (error_status & $past(cpl_err[5:0])) == $past(cpl_err[5:0]))
		else $error("status not set");
	status_keep_a: assert property (1 |=> (error_status & $past(error_status)) == $past(error_status))
		else $error("status lost");
	msg_onehot_a: assert property (msg_valid |-> $onehot(msg_source) && msg_type != 2'h3)
		else $error("message source");
	msg_cor_a: assert property (msg_valid && msg_source[0] |-> msg_type == 2'h0) else $error("timeout type");
	msg_unc_a: assert property (msg_valid && msg_source[1] |-> msg_type == (uncor_severity_fatal[1] ? 2'h2 : 2'h1))
		else $error("severity type");
endmodule // pces_chk
bind pces_sideband pces_chk u_chk (.*);

// ===== verification/pces_app.sv
// application-side model: error reports and own credit use
`timescale 1ns/1ps
module pces_app (
	// from the bench and the block
	input  wire         core_clk,
	input  wire [5:0]   err_req,
	input  wire         app_on,
	input  wire [127:0] hdr_in,
	input  wire [5:0]   core_consumed_credit_pulse,
	// toward the block
	output reg  [6:0]   cpl_err = 0,
	output reg  [127:0] log_hdr = 0,
	output reg  [1:0]   error_phys_function_number = 0,
	output reg          error_from_virtual_function = 0,
	output reg  [10:0]  error_virt_function_offset = 0,
	output reg          app_tlp_use = 0,
	output reg  [1:0]   app_tlp_class = 0,
	output reg          app_tlp_has_data = 0
);
	integer    seed = 56683;
	reg [15:0] used = 0;
	always @(negedge core_clk) begin
		cpl_err <= {|err_req[5:2], err_req};
		// idle header bus shows the inverse so a stale value never passes
		log_hdr <= |err_req[5:2] ? hdr_in : ~log_hdr;
		{error_phys_function_number, error_from_virtual_function, error_virt_function_offset} <= 14'h2805;
		// a refused non-posted request is answered by our own completion
		app_tlp_use <= (err_req[2] | err_req[5]) | (app_on & $random(seed));
		app_tlp_class <= (err_req[2] | err_req[5]) ? 2'h2 : 2'($unsigned($random(seed)) % 3);
		app_tlp_has_data <= $random(seed);
		used <= used + $countones(core_consumed_credit_pulse) + (app_tlp_use ? 1 + app_tlp_has_data : 0);
	end
endmodule // pces_app

// ===== verification/pces_sideband_test.sv
// self-checking bench for the credit and error sideband block
`timescale 1ns/1ps
module pces_sideband_test;
	reg          core_clk = 0, rstn = 0, link_up = 0, limit_load = 1, consumed_select = 0, app_on = 0;
	reg          core_tlp_use = 0, core_tlp_has_data = 0;
	reg  [1:0]   core_tlp_class = 0, credit_class_select = 0;
	reg  [5:0]   infinite_advertised = 0, uncor_severity_fatal = 0, err_req = 0;
	reg  [7:0]   limit_ph, limit_nph, limit_cplh;
	reg  [11:0]  limit_pd, limit_npd, limit_cpld;
	reg  [127:0] hdr_in = 0;
	wire [127:0] log_hdr, logged_header;
	wire [10:0]  error_virt_function_offset, logged_vf_offset;
	wire [11:0]  data_credit_value;
	wire [7:0]   header_credit_value;
	wire [6:0]   cpl_err;
	wire [5:0]   core_consumed_credit_pulse, infinite_credit_flags, error_status, msg_source;
	wire [1:0]   error_phys_function_number, logged_pf, msg_type, app_tlp_class;
	wire         error_from_virtual_function, app_tlp_use, app_tlp_has_data, transmit_ready_out;
	wire         msg_valid, header_logged, logged_vf_active;
	integer      seed = 56683, failures = 0, checks = 0, cyc = 0, i, n, m;
	pces_app u_app (.*);
	pces_sideband u_dut (.*);
	task chk(input [127:0] seen, input [127:0] exp, input [8*8-1:0] what);
		checks = checks + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("unexpected %0s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task tick(input integer k);
		repeat (k) @(negedge core_clk);
	endtask
	function [19:0] lim(input [1:0] c);
		lim = c == 0 ? {limit_ph, limit_pd} : c == 1 ? {limit_nph, limit_npd} : {limit_cplh, limit_cpld};
	endfunction
	function [1:0] exp_type(input integer b, input f);
		exp_type = b == 0 ? 2'h0 : f ? 2'h2 : (b == 1 || b == 4) ? 2'h1 : 2'h0;
	endfunction
	task tally_and_finish;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial forever #4 core_clk = ~core_clk;
	// ceiling well above the fewer than a hundred cycles the run needs
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures = failures + 1;
			tally_and_finish;
		end
	end
	initial begin
		{limit_ph, limit_nph, limit_cplh} = {3{8'h40}} | $random(seed);
		{limit_pd, limit_npd, limit_cpld} = {3{12'h040}} | {$random(seed), $random(seed)};
		tick(4);
		rstn = 1;
		chk(transmit_ready_out, 0, "ready");
		link_up = 1;
		tick(4);
		for (i = 1; i < 4; i = i + 1) begin
			credit_class_select = 2'(i % 3);
			tick(1);
			chk({header_credit_value, data_credit_value}, lim(i - 1), "old");
			tick(1);
			chk({header_credit_value, data_credit_value}, lim(i % 3), "new");
		end
		$display("select test done");
		consumed_select = 1;
		n = 0;
		m = 0;
		for (i = 0; i < 12; i = i + 1) begin
			core_tlp_use = 1;
			core_tlp_class = 2'($unsigned($random(seed)) % 3);
			core_tlp_has_data = $random(seed);
			tick(1);
			chk(core_consumed_credit_pulse, (6'h02 | core_tlp_has_data) << (4 - 2 * core_tlp_class), "pulse");
			n = n + (core_tlp_class == 0);
			m = m + (core_tlp_class == 0 && core_tlp_has_data);
		end
		core_tlp_use = 0;
		tick(3);
		chk({header_credit_value, data_credit_value}, {n[7:0], m[11:0]}, "used");
		$display("credit test done");
		// a limit that is not loaded must not reach the ready logic
		limit_load = 0;
		limit_ph = n;
		tick(3);
		chk(transmit_ready_out, 1, "hold");
		limit_load = 1;
		tick(3);
		chk(transmit_ready_out, 0, "ready");
		limit_ph = n + 1;
		tick(3);
		chk(transmit_ready_out, 1, "ready");
		// an unlimited type must not hold ready low even when its counter meets the limit
		infinite_advertised = $random(seed) | 6'h20;
		limit_ph = n;
		tick(3);
		chk(infinite_credit_flags, infinite_advertised, "inf");
		chk(transmit_ready_out, 1, "ready");
		$display("ready test done");
		uncor_severity_fatal = $random(seed);
		app_on <= 1;
		for (i = 0; i < 6; i = i + 1) begin
			hdr_in = {4{$random(seed)}};
			err_req <= 6'h01 << i;
			tick(1);
			err_req <= 0;
			for (n = 0; n < 20 && msg_valid !== 1'b1; n = n + 1)
				tick(1);
			chk(msg_source, 6'h01 << i, "source");
			chk(msg_type, exp_type(i, uncor_severity_fatal[i]), "type");
			if (i > 1) begin
				chk(logged_header, hdr_in, "header");
				chk(header_logged, 1, "hlog");
			end
			tick(1);
		end
		chk(logged_pf, 2'h2, "pf");
		chk(logged_vf_active, 1, "vf");
		chk(logged_vf_offset, 11'h005, "vfoff");
		err_req <= 6'h0c;
		tick(1);
		err_req <= 0;
		m = 0;
		for (n = 0; n < 10; n = n + 1) begin
			tick(1);
			m = m + (msg_valid === 1'b1);
		end
		chk(m, 2, "msgs");
		chk(error_status, 6'h3f, "status");
		$display("error test done");
		tally_and_finish;
	end
endmodule // pces_sideband_test
